// *** src/tcc_port_ctrl.sv ***
// type-c cc port controller: power-up, role strap, attach, orientation
//
// Implementation choices: the APB register port and the address map.
`default_nettype none
//
// Summary of operation
// [RULE1] unpowered or in reset, both cc lines present sink pulldowns
// [RULE2] after reset release enter unattached and sample role strap
// [RULE3] unattached: watch cc as source, watch vbus as sink
// [RULE4] go active only after attach is detected and debounced
// [RULE5] role strap high selects source-only operation
// [RULE6] current strap high makes source advertise high current
// [RULE7] orientation output steers external superspeed mux
// [RULE8] role strap sampled only once after reset
// [RULE9] orientation pulled low for cc1, released high for cc2
// [RULE10] sink reports current: default h/l, medium l/h, high l/l
// [RULE11] current strap decoded to three levels and latched
module tcc_port_ctrl
  import tcc_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // straps: role hi/lo (both low = open), current strap med/high
  input  wire logic        role_strap_hi,
  input  wire logic        role_strap_lo,
  input  wire logic        cur_strap_med,
  input  wire logic        cur_strap_high,
  // cc comparators: partner rd and rp seen per line, one shared rp level
  input  wire logic        cc1_rd_seen,
  input  wire logic        cc2_rd_seen,
  input  wire logic        cc1_rp_seen,
  input  wire logic        cc2_rp_seen,
  input  wire logic [1:0]  cc_rp_level,
  input  wire logic        vbus_sense_in,
  // terminations
  output logic             cc_pulldown_en,
  output logic             cc_pullup_en,
  output logic [1:0]       cc_adv_level,
  // orientation, open drain
  output logic             orient_out,
  output logic             orient_oe,
  // sink current report, active mode
  output logic             sink_current_flag_a,
  output logic             sink_current_flag_b,
  output logic             port_active,
  output logic             irq
);

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  logic       strap_done;
  tcc_role_t  role;
  tcc_cur_t   adv;
  tcc_role_t  next_role;
  tcc_cur_t   next_adv;

  assign next_role = role_strap_hi ? TCC_ROLE_SRC :           // see [RULE5]
                     role_strap_lo ? TCC_ROLE_SNK : TCC_ROLE_DRP;
  assign next_adv  = cur_strap_high ? TCC_CUR_HIGH :          // see [RULE11]
                     cur_strap_med  ? TCC_CUR_MED  : TCC_CUR_DEF;

  // straps caught on the first edge after release, never again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done <= 1'b0;
      role       <= TCC_ROLE_SNK;
      adv        <= TCC_CUR_DEF;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;                                     // see [RULE8]
      role       <= next_role;                                // see [RULE2]
      adv        <= next_adv;                                 // see [RULE11]
    end
  end

  // ----------------------------------------
  // attach state machine
  // ----------------------------------------
  tcc_state_t       state;
  tcc_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic             src_seen;
  logic             snk_seen;
  logic             deb_done;
  logic             tog_done;
  logic             drp_en;
  logic             cc2_side;

  assign src_seen = cc1_rd_seen ^ cc2_rd_seen;                // see [RULE3]
  assign snk_seen = cc1_rp_seen | cc2_rp_seen;
  // late vbus must still attach, so done is a compare at or above and the count saturates at all ones
  assign deb_done = cnt >= CNT_W'(DEBOUNCE_CYC - 1);
  assign tog_done = cnt == CNT_W'(TOGGLE_CYC - 1);

  always_comb
  begin
    next_state = state;
    unique case (state)
      TCC_ST_UNATT_SNK:
        if (!strap_done)
          next_state = state;                                 // see [RULE2]
        else if (role == TCC_ROLE_SRC)
          next_state = TCC_ST_UNATT_SRC;                      // see [RULE5]
        else if (snk_seen)
          next_state = TCC_ST_WAIT_SNK;
        else if (role == TCC_ROLE_DRP && drp_en && tog_done)
          next_state = TCC_ST_UNATT_SRC;
      TCC_ST_WAIT_SNK:
        if (!snk_seen)
          next_state = TCC_ST_UNATT_SNK;
        else if (deb_done && vbus_sense_in)
          next_state = TCC_ST_ATT_SNK;                        // see [RULE4]
      TCC_ST_UNATT_SRC:
        if (src_seen)
          next_state = TCC_ST_WAIT_SRC;
        else if (role == TCC_ROLE_DRP && tog_done)
          next_state = TCC_ST_UNATT_SNK;
      TCC_ST_WAIT_SRC:
        if (!src_seen)
          next_state = TCC_ST_UNATT_SRC;
        else if (deb_done)
          next_state = TCC_ST_ATT_SRC;                        // see [RULE4]
      TCC_ST_ATT_SNK:
        if (!vbus_sense_in)
          next_state = TCC_ST_UNATT_SNK;
      TCC_ST_ATT_SRC:
        if (!(cc1_rd_seen | cc2_rd_seen))
          next_state = TCC_ST_UNATT_SRC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= TCC_ST_UNATT_SNK;
      cnt      <= '0;
      cc2_side <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : (&cnt) ? cnt : cnt + 1'b1;
      if (next_state == TCC_ST_ATT_SRC && state != TCC_ST_ATT_SRC)
        cc2_side <= cc2_rd_seen;                              // see [RULE9]
      else if (next_state == TCC_ST_ATT_SNK && state != TCC_ST_ATT_SNK)
        cc2_side <= cc2_rp_seen;                              // see [RULE9]
    end
  end

  // ----------------------------------------
  // pin outputs, all registered
  // ----------------------------------------
  logic attached;
  logic as_src;
  assign attached = state == TCC_ST_ATT_SNK || state == TCC_ST_ATT_SRC;
  assign as_src   = state == TCC_ST_UNATT_SRC || state == TCC_ST_WAIT_SRC ||
                    state == TCC_ST_ATT_SRC;

  // reset gives sink pulldowns, as the unpowered pad does
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cc_pulldown_en      <= 1'b1;                            // see [RULE1]
      cc_pullup_en        <= 1'b0;
      cc_adv_level        <= 2'h0;
      orient_out          <= 1'b0;
      orient_oe           <= 1'b0;
      sink_current_flag_a <= 1'b1;
      sink_current_flag_b <= 1'b1;
      port_active         <= 1'b0;
    end
    else
    begin
      cc_pulldown_en <= !as_src;
      cc_pullup_en   <= as_src;
      cc_adv_level   <= adv;                                  // see [RULE6]
      // low on cc1, released (pulled high) on cc2
      orient_out     <= 1'b0;
      orient_oe      <= attached && !cc2_side;                // see [RULE7]
      port_active    <= attached;
      if (state == TCC_ST_ATT_SNK)
      begin
        sink_current_flag_a <= cc_rp_level == TCC_CUR_DEF;    // see [RULE10]
        sink_current_flag_b <= cc_rp_level == TCC_CUR_MED;    // see [RULE10]
      end
      else
      begin
        sink_current_flag_a <= 1'b1;
        sink_current_flag_b <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // interrupts and apb slave
  // ----------------------------------------
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic             drp_ctrl;
  logic             wr;
  logic             rd;
  logic [31:0]      status_word;
  logic [31:0]      next_rdata;
  logic             hit;
  logic             prev_att;

  assign drp_en   = drp_ctrl;
  assign wr       = psel && penable && pwrite;
  assign rd       = psel && !penable && !pwrite;
  assign irq_evt  = {prev_att && !attached, !prev_att && attached};
  assign hit      = paddr == ADDR_STATUS || paddr == ADDR_IRQ ||
                    paddr == ADDR_MASK || paddr == ADDR_CTRL;
  assign status_word = {23'h0, cc_rp_level, adv, cc2_side, as_src, attached, role};
  assign next_rdata  = paddr == ADDR_STATUS ? status_word :
                       paddr == ADDR_IRQ    ? {30'h0, irq_stat} :
                       paddr == ADDR_MASK   ? {30'h0, irq_mask} :
                       paddr == ADDR_CTRL   ? {31'h0, drp_ctrl} : 32'h0;

  // one-cycle access phase; data latched in setup so prdata is a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq_stat <= '0;
      irq_mask <= MASK_RST;
      drp_ctrl <= CTRL_DRP_EN_RST;
      prev_att <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      prev_att <= attached;
      pready   <= psel && !penable;
      pslverr  <= psel && !penable && !hit;
      if (rd)
        prdata <= next_rdata;
      // set wins over write-one-to-clear
      irq_stat <= (irq_stat & ~((wr && paddr == ADDR_IRQ) ? pwdata[IRQ_W-1:0] : '0))
                  | irq_evt;
      if (wr && paddr == ADDR_MASK)
        irq_mask <= pwdata[IRQ_W-1:0];
      if (wr && paddr == ADDR_CTRL)
        drp_ctrl <= pwdata[0];
      // a mask bit set blocks its event
      irq <= |(irq_stat & ~irq_mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PULLDOWN_SNK: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    (state == TCC_ST_UNATT_SNK) |=> cc_pulldown_en)
    else $error("sink state without pulldowns");
  AST_ROLE_HELD: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE8]
    strap_done |=> $stable(role))
    else $error("role changed after strap capture");
  AST_SRC_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE5]
    (strap_done && role == TCC_ROLE_SRC) |-> ##2 !cc_pulldown_en)
    else $error("source-only port shows pulldowns");
  AST_SNK_NEEDS_VBUS: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
    (state == TCC_ST_WAIT_SNK && next_state == TCC_ST_ATT_SNK) |-> vbus_sense_in)
    else $error("sink attached without vbus");
  sequence seq_enter_active;
    !attached ##1 attached;
  endsequence
  AST_ACTIVE_AFTER_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE4]
    seq_enter_active |-> $past(state == TCC_ST_WAIT_SNK || state == TCC_ST_WAIT_SRC))
    else $error("active entered without debounce");
  AST_ADV_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE6]
    (strap_done && adv == TCC_CUR_HIGH) |=> cc_adv_level == TCC_CUR_HIGH)
    else $error("high strap not advertised");
  AST_ORIENT: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE9]
    (attached && !cc2_side) |=> orient_oe && !orient_out)
    else $error("cc1 orientation not pulled low");
  AST_SINK_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE10]
    (state == TCC_ST_ATT_SNK && cc_rp_level == TCC_CUR_HIGH)
      |=> !sink_current_flag_a && !sink_current_flag_b)
    else $error("high current not reported");

endmodule
`default_nettype wire

// *** include/tcc_pkg.sv ***
// package of constants and types for the type-c cc power-up and mode block
`default_nettype none
package tcc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ            = 250;
  // cc debounce time, microseconds; vbus is only sampled once it has run out
  localparam int DEBOUNCE_US        = 100;
  localparam int DEBOUNCE_CYC       = DEBOUNCE_US * CLK_MHZ;
  // drp toggle half period, microseconds
  localparam int TOGGLE_US          = 50;
  localparam int TOGGLE_CYC         = TOGGLE_US * CLK_MHZ;
  localparam int CNT_W              = 16;

  // ----------------------------------------
  // apb register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ    = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;

  // status word field positions
  localparam int ST_ROLE_LSB        = 0;
  localparam int ST_ACTIVE_BIT      = 2;
  localparam int ST_AS_SRC_BIT      = 3;
  localparam int ST_ORIENT_BIT      = 4;
  localparam int ST_ADV_LSB         = 5;
  localparam int ST_DET_LSB         = 7;

  // irq bits: attach, detach
  localparam int IRQ_W              = 2;
  localparam int IRQ_ATTACH_BIT     = 0;
  localparam int IRQ_DETACH_BIT     = 1;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;
  localparam logic CTRL_DRP_EN_RST  = 1'b1;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  typedef enum logic [1:0] {TCC_ROLE_SNK, TCC_ROLE_SRC, TCC_ROLE_DRP} tcc_role_t;
  // current level: default, medium, high
  typedef enum logic [1:0] {TCC_CUR_DEF, TCC_CUR_MED, TCC_CUR_HIGH} tcc_cur_t;
  typedef enum logic [2:0]
  {
    TCC_ST_UNATT_SNK,
    TCC_ST_WAIT_SNK,
    TCC_ST_UNATT_SRC,
    TCC_ST_WAIT_SRC,
    TCC_ST_ATT_SNK,
    TCC_ST_ATT_SRC
  } tcc_state_t;

endpackage
`default_nettype wire

// *** tb/tcc_partner.sv ***
// port partner model at the far end of the cc wires
`default_nettype none
module tcc_partner
#(
  parameter int VBUS_DLY = 27000
)
(
  // plug control
  input  wire logic       pclk,
  input  wire logic       plugged,
  input  wire logic       is_source,
  input  wire logic       on_cc2,
  input  wire logic [1:0] rp_lvl,
  // device terminations
  input  wire logic       cc_pullup_en,
  input  wire logic       cc_pulldown_en,
  // comparator view
  output logic            cc1_rd_seen,
  output logic            cc2_rd_seen,
  output logic            cc1_rp_seen,
  output logic            cc2_rp_seen,
  output logic      [1:0] cc_rp_level,
  output logic            vbus_sense_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int        vbus_cnt = 0;
  // a level only develops against the opposite device termination
  wire logic sees_rd  = plugged && !is_source && cc_pullup_en;
  wire logic sees_rp  = plugged && is_source && cc_pulldown_en;
  assign cc1_rd_seen = sees_rd && !on_cc2;
  assign cc2_rd_seen = sees_rd && on_cc2;
  assign cc1_rp_seen = sees_rp && !on_cc2;
  assign cc2_rp_seen = sees_rp && on_cc2;
  assign cc_rp_level = sees_rp ? rp_lvl : 2'h0;
  // vbus comes late on purpose, after the cc debounce has run out
  always_ff @(posedge pclk)
    vbus_cnt <= sees_rp ? vbus_cnt + 1 : 0;
  assign vbus_sense_in = sees_rp && vbus_cnt >= VBUS_DLY;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the type-c cc power-up and mode block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, rs_hi = 0, rs_lo = 0, cs_med = 0, cs_high = 0;
  logic        c1d, c2d, c1p, c2p, vbus, pd_en, pu_en, o_out, o_oe, fa, fb, act, irq;
  logic [1:0]  rp_lv, adv_lv, rp_sel = 2'h0;
  logic        plugged = 0, is_src = 0, on_cc2 = 0;
  logic [32:0] q[$];
  logic [32:0] m_e;
  logic [15:0] rnd = 16'hc3ad;
  int          n_fail = 0, compares = 0;

  initial forever #2 pclk = ~pclk;

  tcc_port_ctrl i_tcc_port_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .role_strap_hi(rs_hi), .role_strap_lo(rs_lo),
    .cur_strap_med(cs_med), .cur_strap_high(cs_high), .cc1_rd_seen(c1d), .cc2_rd_seen(c2d),
    .cc1_rp_seen(c1p), .cc2_rp_seen(c2p), .cc_rp_level(rp_lv), .vbus_sense_in(vbus),
    .cc_pulldown_en(pd_en), .cc_pullup_en(pu_en), .cc_adv_level(adv_lv),
    .orient_out(o_out), .orient_oe(o_oe), .sink_current_flag_a(fa),
    .sink_current_flag_b(fb), .port_active(act), .irq(irq));
  tcc_partner i_tcc_partner (.pclk(pclk), .plugged(plugged), .is_source(is_src),
    .on_cc2(on_cc2), .rp_lvl(rp_sel), .cc_pullup_en(pu_en), .cc_pulldown_en(pd_en),
    .cc1_rd_seen(c1d), .cc2_rd_seen(c2d), .cc1_rp_seen(c1p), .cc2_rp_seen(c2p),
    .cc_rp_level(rp_lv), .vbus_sense_in(vbus));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // note is {slave error, read data}; write data in a note is ignored
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      m_e = q.pop_front();
      chk("pslverr", pslverr, m_e[32]);
      if (!pwrite)
        chk("prdata", prdata, m_e[31:0]);
    end

  task automatic do_reset(input logic hi, input logic lo, input logic med, input logic high);
    presetn <= 1'b0;
    rs_hi <= hi;
    rs_lo <= lo;
    cs_med <= med;
    cs_high <= high;
    repeat (5) @(posedge pclk);
    chk("pulldown", pd_en, 1);
    chk("pullup", pu_en, 0);
    chk("flags", {fa, fb}, 2'b11);
    presetn <= 1'b1;
    // strap edge, state edge, output edge, then look
    repeat (4) @(posedge pclk);
  endtask

  task automatic wait_active(input logic want, input int lim);
    int n;
    n = 0;
    while (act !== want && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("active", act, want);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    do_reset(0, 0, 1, 0);
    chk("adv", adv_lv, 2'(TCC_CUR_MED));
    apb(0, ADDR_STATUS, 0, {1'b0, 32'(TCC_ROLE_DRP) | 32'(TCC_CUR_MED) << ST_ADV_LSB});
    apb(0, ADDR_CTRL, 0, {1'b0, 32'(CTRL_DRP_EN_RST)});
    apb(0, ADDR_MASK, 0, {1'b0, 32'(MASK_RST)});
    rnd = lfsr(rnd);
    apb(1, 8'h10, {rnd, ~rnd}, {1'b1, 32'h0});
    apb(0, 8'h10, 0, {1'b1, 32'h0});
    // source only, high current; later strap change must be ignored
    do_reset(1, 0, 0, 1);
    chk("pullup", pu_en, 1);
    chk("adv", adv_lv, 2'(TCC_CUR_HIGH));
    rs_hi <= 1'b0;
    rs_lo <= 1'b1;
    apb(1, ADDR_MASK, 32'h3, 33'h0);
    plugged <= 1'b1;
    repeat (24000) @(posedge pclk);
    chk("active", act, 0);
    wait_active(1, 2000);
    chk("orient_oe", o_oe, 1);
    chk("orient_out", o_out, 0);
    chk("irq", irq, 0);
    apb(0, ADDR_STATUS, 0, {1'b0, 32'(TCC_ROLE_SRC) | 32'h0c | 32'(TCC_CUR_HIGH) << ST_ADV_LSB});
    apb(0, ADDR_IRQ, 0, {1'b0, 32'h1});
    apb(1, ADDR_MASK, 32'h0, 33'h0);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1);
    apb(1, ADDR_IRQ, 32'h1, 33'h0);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 0);
    apb(0, ADDR_IRQ, 0, 33'h0);
    // sink only, partner on cc2 offering medium current, vbus late
    plugged <= 1'b0;
    do_reset(0, 1, 0, 0);
    chk("pulldown", pd_en, 1);
    is_src <= 1'b1;
    on_cc2 <= 1'b1;
    rp_sel <= 2'h1;
    plugged <= 1'b1;
    repeat (26000) @(posedge pclk);
    chk("active", act, 0);
    wait_active(1, 3000);
    chk("flags", {fa, fb}, 2'b01);
    chk("orient_oe", o_oe, 0);
    apb(0, ADDR_STATUS, 0, {1'b0, 32'(TCC_ROLE_SNK) | 32'h14 | 32'h1 << ST_DET_LSB});
    report_and_stop();
  end

  // cut a hang short well after the longest debounce path
  initial
  begin
    repeat (120000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
